/* verilog/cpdm_regs.vh */
`ifndef CPDM_REGS_VH
`define CPDM_REGS_VH
// Clock rate and time base
`define CPDM_CLK_HZ 125000000
`define CPDM_MS_CYCLES (`CPDM_CLK_HZ / 1000)
// Dwell settings are in milliseconds
`define CPDM_DWELL_W 14
`define CPDM_DOWN_MIN_MS 14'h0001
`define CPDM_DWELL_MAX_MS 14'h270F
`define CPDM_UP_MIN_MS 14'h0000
// Quadrature counts per encoder line
`define CPDM_QUAD_MULT 4
// Stroke sequencer states
`define CPDM_ST_IDLE 2'h0
`define CPDM_ST_DOWN 2'h1
`define CPDM_ST_UP 2'h2
`endif

/* verilog/cpdm_quad_counter.v */
`timescale 1ns/1ps
// Quadrature decoder: counts every edge of A and B, so one line gives four counts
module cpdm_quad_counter #(
   parameter CW = 32
) (
   input wire clk,
   input wire nrst,
   input wire encA,
   input wire encB,
   input wire clrCount,
   output reg signed [CW-1:0] count_q
);
   reg [2:0] aSync_q;
   reg [2:0] bSync_q;
   reg aState_q;
   reg bState_q;
   wire aStable;
   wire bStable;
   wire stepA;
   wire stepB;
   wire up;

   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   // Three stages, a change counts once stages two and three agree
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aSync_q <= 3'h0;
         bSync_q <= 3'h0;
         aState_q <= 1'b0;
         bState_q <= 1'b0;
      end else begin
         aSync_q <= {aSync_q[1:0], encA};
         bSync_q <= {bSync_q[1:0], encB};
         if (aStable) aState_q <= aSync_q[1];
         if (bStable) bState_q <= bSync_q[1];
      end
   end

   assign aStable = (aSync_q[1] == aSync_q[2]);
   assign bStable = (bSync_q[1] == bSync_q[2]);
   assign stepA = aStable && (aSync_q[1] != aState_q);
   assign stepB = bStable && (bSync_q[1] != bState_q);
   // Direction from the new A against the held B, or the reverse
   assign up = stepA ? (aSync_q[1] != bState_q) : (bSync_q[1] == aState_q);

   // ---------------------------------------------
   // Edge counter
   // ---------------------------------------------
   // A double step is an encoder fault and is dropped
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= {CW{1'b0}};
      end else if (clrCount) begin
         count_q <= {CW{1'b0}};
      end else if (stepA ^ stepB) begin
         count_q <= up ? count_q + 1'b1 : count_q - 1'b1;
      end
   end
endmodule // cpdm_quad_counter

/* verilog/cpdm_die_motion.v */
`timescale 1ns/1ps
`include "cpdm_regs.vh"
// Behaviour
// - Stroke-down output stays on for programmed 0.001 to 9.999 s.
// - Without press assist, stroke-up dwell programmable from 0 to 9.999 s.
// - Stroke-complete closure during down dwell ends the output at once.
// - Stroke-up dwell runs full time, ignoring stroke-complete.
// - Every quadrature edge counts: four counts per rated encoder line.
// - Line length equals line pulse count times line length-per-pulse.
// - Die position equals motor count times die travel-per-count.
// - Motor command corrects position error, scaled by loop gain.
// - Forward velocity change limited by forward acceleration.
// - Reverse velocity change limited by return acceleration.
// - Jog command moves die at programmed jog velocity.
// - Return to home capped at maximum return velocity.
// - Configuration switches take effect only after power cycle.
module cpdm_die_motion #(
   parameter CW = 32,
   parameter RW = 16,
   parameter VW = 16,
   parameter OW = 24,
   parameter MS_CYCLES = `CPDM_MS_CYCLES
) (
   input wire clk,
   input wire nrst,
   input wire strokeReq,
   input wire strokeComplete,
   input wire pressAssistFitted,
   input wire [`CPDM_DWELL_W-1:0] downDwellMs,
   input wire [`CPDM_DWELL_W-1:0] upDwellMs,
   input wire lineEncA,
   input wire lineEncB,
   input wire motorEncA,
   input wire motorEncB,
   input wire lineDirInvert,
   input wire motorDirInvert,
   input wire analogInvert,
   input wire [RW-1:0] lineResolution,
   input wire [RW-1:0] dieResolution,
   input wire [7:0] loopGain,
   input wire [VW-1:0] fwdAccel,
   input wire [VW-1:0] retAccel,
   input wire [VW-1:0] jogVelocity,
   input wire [VW-1:0] maxReturnVelocity,
   input wire jogFwd,
   input wire jogRev,
   input wire returnHome,
   input wire signed [VW-1:0] targetVelocity,
   input wire signed [CW+RW-1:0] commandPosition,
   input wire dieHome,
   output reg strokeDown_q,
   output reg strokeBusy_q,
   output reg signed [CW+RW-1:0] lineLength_q,
   output reg signed [CW+RW-1:0] diePosition_q,
   output reg signed [VW-1:0] velocityCmd_q,
   output reg signed [OW-1:0] motorCmd_q,
   output reg atHome_q
);
   localparam SW = 3;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [31:0] tick_q;
   reg [`CPDM_DWELL_W-1:0] msLeft_q;
   reg [SW-1:0] cmpSync_q;
   reg [SW-1:0] reqSync_q;
   reg [SW-1:0] homeSync_q;
   reg reqSeen_q;
   reg cfgLatched_q;
   reg lineInv_q;
   reg motorInv_q;
   reg anaInv_q;
   wire msTick;
   wire cmpClosed;
   wire reqRise;
   wire signed [CW-1:0] lineCountRaw;
   wire signed [CW-1:0] motorCountRaw;
   wire signed [CW-1:0] lineCount;
   wire signed [CW-1:0] motorCount;
   reg signed [VW:0] goal;
   reg signed [VW:0] step;
   reg signed [VW:0] nextVel;
   reg signed [CW+RW+8:0] corr;
   reg signed [OW-1:0] drive;

   // -------------------------------------------------
   // Configuration latch
   // -------------------------------------------------
   // Switch settings caught once after reset release only
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfgLatched_q <= 1'b0;
         lineInv_q <= 1'b0;
         motorInv_q <= 1'b0;
         anaInv_q <= 1'b0;
      end else if (!cfgLatched_q) begin
         cfgLatched_q <= 1'b1;
         lineInv_q <= lineDirInvert;
         motorInv_q <= motorDirInvert;
         anaInv_q <= analogInvert;
      end
   end

   // -------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmpSync_q <= 3'h0;
         reqSync_q <= 3'h0;
         homeSync_q <= 3'h0;
         reqSeen_q <= 1'b0;
         atHome_q <= 1'b0;
      end else begin
         cmpSync_q <= {cmpSync_q[1:0], strokeComplete};
         reqSync_q <= {reqSync_q[1:0], strokeReq};
         homeSync_q <= {homeSync_q[1:0], dieHome};
         if (reqSync_q[1] == reqSync_q[2]) reqSeen_q <= reqSync_q[1];
         if (homeSync_q[1] == homeSync_q[2]) atHome_q <= homeSync_q[1];
      end
   end

   assign cmpClosed = cmpSync_q[1] & cmpSync_q[2];
   assign reqRise = reqSync_q[1] & reqSync_q[2] & ~reqSeen_q;

   // -------------------------------------------------
   // Millisecond tick
   // -------------------------------------------------
   assign msTick = (tick_q == MS_CYCLES - 1);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_q <= 32'h0;
      end else if (state_q == `CPDM_ST_IDLE || state_d != state_q || msTick) begin
         tick_q <= 32'h0;
      end else begin
         tick_q <= tick_q + 32'h1;
      end
   end

   // -------------------------------------------------
   // Stroke sequencer
   // -------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         `CPDM_ST_IDLE: begin
            if (reqRise) state_d = `CPDM_ST_DOWN;
         end
         `CPDM_ST_DOWN: begin
            if (cmpClosed) state_d = `CPDM_ST_UP;
            else if (msTick && msLeft_q <= 14'h0001) state_d = `CPDM_ST_UP;
         end
         `CPDM_ST_UP: begin
            if (pressAssistFitted || msLeft_q == `CPDM_UP_MIN_MS) state_d = `CPDM_ST_IDLE;
            else if (msTick && msLeft_q == 14'h0001) state_d = `CPDM_ST_IDLE;
         end
         default: state_d = `CPDM_ST_IDLE;
      endcase
   end

   // Dwell counter and outputs, up dwell loaded when down ends
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= `CPDM_ST_IDLE;
         msLeft_q <= 14'h0000;
         strokeDown_q <= 1'b0;
         strokeBusy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         strokeDown_q <= (state_d == `CPDM_ST_DOWN);
         strokeBusy_q <= (state_d != `CPDM_ST_IDLE);
         if (state_q == `CPDM_ST_IDLE && state_d == `CPDM_ST_DOWN) begin
            if (downDwellMs < `CPDM_DOWN_MIN_MS) msLeft_q <= `CPDM_DOWN_MIN_MS;
            else if (downDwellMs > `CPDM_DWELL_MAX_MS) msLeft_q <= `CPDM_DWELL_MAX_MS;
            else msLeft_q <= downDwellMs;
         end else if (state_q == `CPDM_ST_DOWN && state_d == `CPDM_ST_UP) begin
            msLeft_q <= (upDwellMs > `CPDM_DWELL_MAX_MS) ? `CPDM_DWELL_MAX_MS : upDwellMs;
         end else if (msTick && msLeft_q != 14'h0000) begin
            msLeft_q <= msLeft_q - 14'h0001;
         end
      end
   end

   // -------------------------------------------------
   // Encoders and scaling
   // -------------------------------------------------
   cpdm_quad_counter #(.CW(CW)) uLineEnc (
      .clk(clk),
      .nrst(nrst),
      .encA(lineEncA),
      .encB(lineEncB),
      .clrCount(1'b0),
      .count_q(lineCountRaw)
   );

   cpdm_quad_counter #(.CW(CW)) uMotorEnc (
      .clk(clk),
      .nrst(nrst),
      .encA(motorEncA),
      .encB(motorEncB),
      .clrCount(1'b0),
      .count_q(motorCountRaw)
   );

   assign lineCount = lineInv_q ? -lineCountRaw : lineCountRaw;
   assign motorCount = motorInv_q ? -motorCountRaw : motorCountRaw;

   // Length and position products
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lineLength_q <= {(CW+RW){1'b0}};
         diePosition_q <= {(CW+RW){1'b0}};
      end else begin
         lineLength_q <= lineCount * $signed({1'b0, lineResolution});
         diePosition_q <= motorCount * $signed({1'b0, dieResolution});
      end
   end

   // -------------------------------------------------
   // Velocity profile
   // -------------------------------------------------
   always @* begin
      goal = {targetVelocity[VW-1], targetVelocity};
      if (jogFwd) goal = $signed({1'b0, jogVelocity});
      else if (jogRev) goal = -$signed({1'b0, jogVelocity});
      else if (returnHome) begin
         if (atHome_q) goal = {(VW+1){1'b0}};
         else goal = -$signed({1'b0, maxReturnVelocity});
      end
      if (returnHome && goal < -$signed({1'b0, maxReturnVelocity})) goal = -$signed({1'b0, maxReturnVelocity});
      // Forward uses forward rate, reverse uses return rate
      if (goal >= 0 && velocityCmd_q >= 0) step = $signed({1'b0, fwdAccel});
      else step = $signed({1'b0, retAccel});
      if (goal > velocityCmd_q + step) nextVel = velocityCmd_q + step;
      else if (goal < velocityCmd_q - step) nextVel = velocityCmd_q - step;
      else nextVel = goal;
      corr = (commandPosition - diePosition_q) * $signed({1'b0, loopGain});
      // Velocity sign-extended so reverse motion adds correctly
      drive = $signed(corr[OW-1:0]) + {{(OW-VW){velocityCmd_q[VW-1]}}, velocityCmd_q};
   end

   // Velocity command and motor drive command
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         velocityCmd_q <= {VW{1'b0}};
         motorCmd_q <= {OW{1'b0}};
      end else begin
         velocityCmd_q <= nextVel[VW-1:0];
         motorCmd_q <= anaInv_q ? -drive : drive;
      end
   end
endmodule // cpdm_die_motion

/* tb/cpdm_die_motion_monitor.sv */
`timescale 1ns/1ps
// ----------
// Stroke and ramp checker
// ----------
module cpdm_die_motion_monitor #(
   parameter VW = 16
) (
   input wire clk,
   input wire nrst,
   input wire strokeComplete,
   input wire pressAssistFitted,
   input wire [13:0] upDwellMs,
   input wire [VW-1:0] fwdAccel,
   input wire [VW-1:0] retAccel,
   input wire [VW-1:0] jogVelocity,
   input wire [VW-1:0] maxReturnVelocity,
   input wire jogFwd,
   input wire returnHome,
   input wire strokeDown_q,
   input wire strokeBusy_q,
   input wire signed [VW-1:0] velocityCmd_q
);
   reg signed [VW-1:0] velPrev_q;
   wire signed [VW:0] velStep = velocityCmd_q - velPrev_q;
   // Previous velocity for step size
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         velPrev_q <= {VW{1'b0}};
      end else begin
         velPrev_q <= velocityCmd_q;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Stroke steps
   sequence downEnd;
      $fell(strokeDown_q);
   endsequence
   sequence noUpDwell;
      pressAssistFitted || upDwellMs == 14'h0000;
   endsequence
   down_in_busy_a: assert property (strokeDown_q |-> strokeBusy_q)
      else $error("stroke down outside busy");
   down_starts_a: assert property ($rose(strokeDown_q) |-> $rose(strokeBusy_q))
      else $error("stroke down began while busy");
   down_min_a: assert property ($rose(strokeDown_q) && !strokeComplete |=> strokeDown_q [*6])
      else $error("stroke down too short");
   cut_short_a: assert property (strokeDown_q && strokeComplete |-> ##[1:6] !strokeDown_q)
      else $error("stroke complete did not end down");
   skip_up_a: assert property (downEnd ##0 noUpDwell |=> !strokeBusy_q)
      else $error("busy held without up dwell");
   up_full_a: assert property (downEnd ##0 (!pressAssistFitted && upDwellMs != 14'h0000) |=> strokeBusy_q [*8])
      else $error("up dwell cut short");
   fwd_ramp_a: assert property (velPrev_q >= 0 && velStep > 0 |-> velStep <= $signed({1'b0, fwdAccel}))
      else $error("forward step too large");
   ret_ramp_a: assert property (velPrev_q < 0 |-> velStep >= -$signed({1'b0, retAccel})
      && velStep <= $signed({1'b0, retAccel}))
      else $error("reverse step too large");
   jog_hold_a: assert property (jogFwd && velocityCmd_q == $signed(jogVelocity)
      |=> velocityCmd_q == $signed(jogVelocity))
      else $error("jog speed not held");
   ret_cap_a: assert property (returnHome && !jogFwd |-> velocityCmd_q >= -$signed({1'b0, maxReturnVelocity}))
      else $error("return speed above cap");
endmodule // cpdm_die_motion_monitor

bind cpdm_die_motion cpdm_die_motion_monitor #(.VW(VW)) mon (.clk(clk), .nrst(nrst),
   .strokeComplete(strokeComplete), .pressAssistFitted(pressAssistFitted), .upDwellMs(upDwellMs),
   .fwdAccel(fwdAccel), .retAccel(retAccel), .jogVelocity(jogVelocity), .maxReturnVelocity(maxReturnVelocity),
   .jogFwd(jogFwd), .returnHome(returnHome), .strokeDown_q(strokeDown_q), .strokeBusy_q(strokeBusy_q),
   .velocityCmd_q(velocityCmd_q));

/* tb/cpdm_quad_model.sv */
`timescale 1ns/1ps
// Quadrature encoder, one edge per step
module cpdm_quad_model (
   input wire clk,
   input wire stepFwd,
   input wire stepRev,
   output wire encA,
   output wire encB
);
   reg [1:0] phase_q = 2'h0;
   // Step the phase one edge at a time
   always @(posedge clk) begin
      if (stepFwd) begin
         phase_q <= phase_q + 2'h1;
      end else if (stepRev) begin
         phase_q <= phase_q - 2'h1;
      end
   end
   // Gray-coded phase onto the channels
   assign encA = phase_q[1] ^ phase_q[0]; // A leads B when stepping forward
   assign encB = phase_q[1];
endmodule // cpdm_quad_model

/* tb/cpdm_die_motion_tb_top.sv */
`timescale 1ns/1ps
module cpdm_die_motion_tb_top;
   logic clk = 1'b0, nrst = 1'b0, strokeReq = 1'b0, strokeComplete = 1'b0, pressAssistFitted = 1'b0;
   logic motorDirInvert = 1'b0, jogFwd = 1'b0, jogRev = 1'b0, returnHome = 1'b0, dieHome = 1'b0;
   logic lStep = 1'b0, mStep = 1'b0, mRev = 1'b0;
   logic [13:0] downDwellMs = 14'h0000, upDwellMs = 14'h0000;
   logic [15:0] fwdAccel = 16'h0004, retAccel = 16'h0006, jogVelocity = 16'h0028, maxReturnVelocity = 16'h001E;
   logic [15:0] lineResolution = 16'h0005, dieResolution = 16'h0003;
   logic [7:0] loopGain = 8'h02;
   logic signed [47:0] commandPosition = 48'h00000000003C;
   wire lineEncA, lineEncB, motorEncA, motorEncB, strokeDown_q, strokeBusy_q, atHome_q;
   wire signed [47:0] lineLength_q, diePosition_q;
   wire signed [15:0] velocityCmd_q;
   wire signed [23:0] motorCmd_q;
   int badCount = 0, comparisons = 0, cycles = 0, d, u;
   cpdm_quad_model lineEnc (.clk(clk), .stepFwd(lStep), .stepRev(1'b0), .encA(lineEncA), .encB(lineEncB));
   cpdm_quad_model motorEnc (.clk(clk), .stepFwd(mStep), .stepRev(mRev), .encA(motorEncA), .encB(motorEncB));
   cpdm_die_motion #(.MS_CYCLES(10)) dut (.clk(clk), .nrst(nrst), .strokeReq(strokeReq),
      .strokeComplete(strokeComplete), .pressAssistFitted(pressAssistFitted), .downDwellMs(downDwellMs),
      .upDwellMs(upDwellMs), .lineEncA(lineEncA), .lineEncB(lineEncB), .motorEncA(motorEncA),
      .motorEncB(motorEncB), .lineDirInvert(1'b0), .motorDirInvert(motorDirInvert), .analogInvert(1'b0),
      .lineResolution(lineResolution), .dieResolution(dieResolution), .loopGain(loopGain),
      .fwdAccel(fwdAccel), .retAccel(retAccel), .jogVelocity(jogVelocity), .maxReturnVelocity(maxReturnVelocity),
      .jogFwd(jogFwd), .jogRev(jogRev), .returnHome(returnHome), .targetVelocity(16'h0000),
      .commandPosition(commandPosition), .dieHome(dieHome), .strokeDown_q(strokeDown_q),
      .strokeBusy_q(strokeBusy_q), .lineLength_q(lineLength_q), .diePosition_q(diePosition_q),
      .velocityCmd_q(velocityCmd_q), .motorCmd_q(motorCmd_q), .atHome_q(atHome_q));
   // Clock at 125 MHz
   initial begin
      forever #4 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         badCount++;
         endSim;
      end
   end
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task endSim;
      $display("Checks %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic stroke(input [13:0] dn, up, input pa, input int cut, output int dnN, upN);
      int w = 0;
      @(negedge clk);
      downDwellMs = dn;
      upDwellMs = up;
      pressAssistFitted = pa;
      strokeReq = 1'b1;
      dnN = 0;
      upN = 0;
      while (strokeDown_q !== 1'b1 && w < 20) begin
         @(negedge clk);
         w++;
      end
      strokeReq = 1'b0;
      while (strokeDown_q === 1'b1 && dnN < 1000) begin
         dnN++;
         if (dnN == cut) strokeComplete = 1'b1;
         @(negedge clk);
      end
      strokeComplete = 1'b1;
      // Request and closure during the up dwell
      while (strokeBusy_q === 1'b1 && upN < 1000) begin
         upN++;
         strokeReq = (upN > 2 && upN < 6);
         @(negedge clk);
      end
      strokeComplete = 1'b0;
      strokeReq = 1'b0;
      repeat (10) @(negedge clk);
   endtask
   task automatic pulse(ref logic s, input int n);
      repeat (n) begin
         s = 1'b1;
         @(negedge clk);
         s = 1'b0;
         @(negedge clk);
      end
   endtask
   task testStrokes;
      stroke(14'h0003, 14'h0002, 1'b0, 0, d, u);
      chk("downLen", d inside {[29:31]}, 1);
      chk("upLen", u inside {[19:22]}, 1);
      chk("reqIgnored", strokeDown_q, 0);
      stroke(14'h0000, 14'h0000, 1'b0, 0, d, u);
      chk("minDown", d inside {[9:11]}, 1);
      chk("zeroUp", u, 1);
      stroke(14'h0032, 14'h0005, 1'b1, 8, d, u);
      chk("cutDown", d inside {[10:15]}, 1);
      chk("assistUp", u, 1);
      // Cut-short down followed by a full 1 ms up dwell
      stroke(14'h0032, 14'h0001, 1'b0, 8, d, u);
      chk("cutDown2", d inside {[10:15]}, 1);
      chk("upAfterCut", u inside {[9:11]}, 1);
   endtask
   task testEncoders;
      motorDirInvert = 1'b1;
      pulse(mStep, 20);
      pulse(lStep, 12);
      pulse(mRev, 2);
      repeat (8) @(negedge clk);
      chk("diePos", diePosition_q, 48'h36);
      chk("lineLen", lineLength_q, 48'h3C);
      chk("motorCmd", motorCmd_q, 48'hC);
   endtask
   task testMotion;
      jogFwd = 1'b1;
      repeat (20) @(negedge clk);
      chk("jogVel", velocityCmd_q, 48'h28);
      jogFwd = 1'b0;
      repeat (20) @(negedge clk);
      chk("stopVel", velocityCmd_q, 48'h0);
      returnHome = 1'b1;
      repeat (20) @(negedge clk);
      chk("retVel", velocityCmd_q, 48'hFFFFFFFFFFE2);
      dieHome = 1'b1;
      repeat (20) @(negedge clk);
      chk("homeStop", {atHome_q, velocityCmd_q}, 48'h10000);
      returnHome = 1'b0;
      jogRev = 1'b1;
      repeat (20) @(negedge clk);
      chk("jogRevVel", velocityCmd_q, 48'hFFFFFFFFFFD8);
      jogRev = 1'b0;
      repeat (20) @(negedge clk);
      chk("revStop", velocityCmd_q, 48'h0);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      chk("resetOut", {strokeDown_q, strokeBusy_q, atHome_q, velocityCmd_q}, 48'h0);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      testStrokes;
      testEncoders;
      testMotion;
      endSim;
   end
endmodule // cpdm_die_motion_tb_top
